//--- verilog/eax_pkg.sv
// package: constants and carrier types for the enclave exit and leaf decode block
package eax_pkg;

  // ==========================================
  // leaf selectors
  localparam logic [31:0] SUP_LEAF_LAST = 32'h00000013;
  localparam logic [31:0] USR_LEAF_LAST_CONTIG = 32'h00000007;
  localparam logic [31:0] USR_FRAME_DECREMENT_LEAF = 32'h00000009;
  localparam logic [31:0] USR_ENTRY_LEAF = 32'h00000002;
  localparam logic [31:0] USR_RESUME_LEAF = 32'h00000003;
  localparam logic [31:0] USR_LEAVE_LEAF = 32'h00000004;
  localparam logic [31:0] SUP_DEBUG_READ_LEAF = 32'h00000004;
  localparam logic [31:0] SUP_DEBUG_WRITE_LEAF = 32'h00000005;

  // ==========================================
  // exit record and misc constants
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_PAGE_FAULT = 8'h0e;
  localparam logic [2:0] EXIT_TYPE_BREAKPOINT = 3'h6;
  localparam logic [2:0] EXIT_TYPE_OTHER = 3'h3;
  localparam logic [63:0] FAULT_ADDR_LOW_MASK = 64'h0000000000000fff;
  localparam logic [15:0] FRAME_INDEX_STEP = 16'h0001;
  localparam logic [1:0] TRACKER_WAIT_FOR_TARGET = 2'h1;
  localparam int NUM_CODE_BP = 4;

  // ==========================================
  // operand roles of the implicit registers
  typedef enum logic [3:0] {
    EAX_ROLE_NONE = 4'h0,
    EAX_ROLE_IN = 4'h1,
    EAX_ROLE_PAGE_DESC = 4'h2,
    EAX_ROLE_PAGE_ADDR = 4'h3,
    EAX_ROLE_DATA_IN = 4'h4,
    EAX_ROLE_DATA_OUT = 4'h5,
    EAX_ROLE_STRUCT_ADDR = 4'h6,
    EAX_ROLE_HANDLER_IN = 4'h7,
    EAX_ROLE_RETURN_OUT = 4'h8,
    EAX_ROLE_TARGET_IN = 4'h9,
    EAX_ROLE_HANDLER_OUT = 4'ha,
    EAX_ROLE_VERSION = 4'hb,
    EAX_ROLE_FRAME_OUT = 4'hc
  } eax_role_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic wide;
    eax_role_t eax_role;
    eax_role_t rbx_role;
    eax_role_t rcx_role;
    eax_role_t rdx_role;
  } eax_decode_t;

  typedef struct packed {
    logic valid;
    logic [2:0] exit_type;
    logic [7:0] vector;
  } eax_exit_info_t;

  typedef struct packed {
    logic ibt_sup;
    logic ss_sup;
    logic encl_cap;
    logic cr4_cet;
    logic shadow_stack_enable;
    logic branch_tracking_enable;
    logic [1:0] tracker;
    logic suppress;
  } eax_flow_t;

endpackage : eax_pkg

//--- verilog/eax_leaf_decode.sv
// leaf decoder: selector to operand roles for both instruction classes
`timescale 1ns/1ps
module eax_leaf_decode import eax_pkg::*; (
  input wire logic is_supervisor,
  input wire logic [31:0] selector,
  input wire logic mode64,
  output eax_decode_t dec
);

  // ==========================================
  // range checks
  wire logic sup_ok = (selector <= SUP_LEAF_LAST); // see RULE_04
  wire logic usr_ok = (selector <= USR_LEAF_LAST_CONTIG) ||
                      (selector == USR_FRAME_DECREMENT_LEAF); // see RULE_05
  wire logic leaf_ok = is_supervisor ? sup_ok : usr_ok; // see RULE_01
  wire logic [4:0] idx = selector[4:0];

  eax_role_t rbx_s, rcx_s, rdx_s, rbx_u, rcx_u, rdx_u, eax_u;

  // ==========================================
  // supervisor-class role table
  always_comb begin // see RULE_04
    rbx_s = EAX_ROLE_PAGE_DESC;
    rcx_s = EAX_ROLE_PAGE_ADDR;
    rdx_s = EAX_ROLE_NONE;
    case (idx)
      5'h00: rcx_s = EAX_ROLE_PAGE_DESC;
      5'h02: begin
        rbx_s = EAX_ROLE_STRUCT_ADDR;
        rcx_s = EAX_ROLE_STRUCT_ADDR;
        rdx_s = EAX_ROLE_STRUCT_ADDR;
      end
      5'h03, 5'h09, 5'h0c, 5'h11: rbx_s = EAX_ROLE_NONE;
      5'h04: rbx_s = EAX_ROLE_DATA_OUT; // see RULE_07
      5'h05: rbx_s = EAX_ROLE_DATA_IN; // see RULE_07
      5'h06: rbx_s = EAX_ROLE_STRUCT_ADDR;
      5'h07, 5'h12, 5'h13: rdx_s = EAX_ROLE_VERSION;
      5'h08: rcx_s = EAX_ROLE_PAGE_DESC;
      5'h0a: rbx_s = EAX_ROLE_DATA_IN;
      5'h0e, 5'h0f, 5'h10: rbx_s = EAX_ROLE_STRUCT_ADDR;
      default: rdx_s = EAX_ROLE_NONE;
    endcase
  end

  // ==========================================
  // user-class role table
  always_comb begin // see RULE_03
    eax_u = EAX_ROLE_IN;
    rbx_u = EAX_ROLE_STRUCT_ADDR;
    rcx_u = EAX_ROLE_PAGE_ADDR;
    rdx_u = EAX_ROLE_NONE;
    case (idx)
      5'h00: rcx_u = EAX_ROLE_STRUCT_ADDR;
      5'h01: rcx_u = EAX_ROLE_STRUCT_ADDR;
      5'h02: begin // see RULE_06
        eax_u = EAX_ROLE_FRAME_OUT;
        rcx_u = EAX_ROLE_RETURN_OUT;
      end
      5'h03: rcx_u = EAX_ROLE_HANDLER_IN;
      5'h04: begin
        rbx_u = EAX_ROLE_TARGET_IN;
        rcx_u = EAX_ROLE_HANDLER_OUT;
      end
      5'h07: rdx_u = EAX_ROLE_PAGE_ADDR;
      5'h09: begin
        rbx_u = EAX_ROLE_NONE;
        rcx_u = EAX_ROLE_NONE;
      end
      default: rdx_u = EAX_ROLE_NONE;
    endcase
  end

  // faulting selectors carry no roles, so nothing downstream can act on them
  assign dec.valid = leaf_ok;
  assign dec.fault = !leaf_ok; // see RULE_26
  assign dec.wide = mode64; // see RULE_02
  assign dec.eax_role = !leaf_ok ? EAX_ROLE_NONE : (is_supervisor ? EAX_ROLE_IN : eax_u);
  assign dec.rbx_role = !leaf_ok ? EAX_ROLE_NONE : (is_supervisor ? rbx_s : rbx_u);
  assign dec.rcx_role = !leaf_ok ? EAX_ROLE_NONE : (is_supervisor ? rcx_s : rcx_u);
  assign dec.rdx_role = !leaf_ok ? EAX_ROLE_NONE : (is_supervisor ? rdx_s : rdx_u);

endmodule : eax_leaf_decode

//--- verilog/eax_exit_unit.sv
// enclave asynchronous exit sequencer with leaf decode front end
// Contract
// RULE_01 - leaf chosen by eax value
// RULE_02 - ignore default-size; 64 or 32 wide
// RULE_03 - leaf operands from rbx rcx rdx
// RULE_04 - decode supervisor leaves 00h to 13h
// RULE_05 - decode user leaves 00h-07h and 09h
// RULE_06 - entry leaf: struct, handler in; frame, return out; code decodes rcx as return out only, no handler in
// RULE_07 - debug read/write data in rbx
// RULE_08 - ip loads the exit handler address
// RULE_09 - eax gets resume leaf value 3
// RULE_10 - rbx gets thread struct linear address
// RULE_11 - rcx gets exit handler address
// RULE_12 - save frame index increments by one
// RULE_13 - restore ext-feature ctrl if enabled
// RULE_14 - re-enable breakpoints outside protected range
// RULE_15 - save shadow stack pointer when enabled
// RULE_16 - save tracker and suppress when tracking
// RULE_17 - restore host flow-protect state, tracker wait
// RULE_18 - clear protected mode then flush translations
// RULE_19 - no debug opt-in: unsuppress all monitoring
// RULE_20 - pend monitor trap exit if enabled
// RULE_21 - page fault clears low 12 address bits
// RULE_22 - hand off to normal event delivery
// RULE_23 - exit runs on events in enclave mode
// RULE_24 - record vector, exit type, valid
// RULE_25 - exit sequence is uninterruptible
// RULE_26 - bad selector raises invalid opcode fault
`timescale 1ns/1ps
module eax_exit_unit import eax_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  // leaf decode request
  input wire logic insn_valid,
  input wire logic insn_is_supervisor,
  input wire logic [31:0] insn_eax,
  input wire logic efer_long_active,
  input wire logic cs_long,
  output eax_decode_t insn_decode,
  output logic insn_fault,
  // event arrival
  input wire logic event_valid,
  input wire logic [7:0] event_vector,
  input wire logic event_reported,
  // enclave context
  input wire logic protected_mode_flag_set,
  input wire logic [63:0] exit_handler_pointer,
  input wire logic [63:0] thread_struct_linear_addr,
  input wire logic [15:0] current_save_frame_index,
  input wire logic os_ext_state_enable,
  input wire logic [63:0] saved_ext_feature_ctrl,
  input wire logic [NUM_CODE_BP-1:0] bp_outside_range,
  input wire logic debug_opt_in_flag,
  input wire logic saved_trap_flag,
  input wire logic monitor_trap_ctrl,
  input wire logic [63:0] fault_addr_in,
  input eax_flow_t flow_in,
  input wire logic [63:0] shadow_stack_pointer,
  input wire logic [63:0] saved_host_shadow_pointer,
  input eax_flow_t saved_host_flow,
  // exit results
  output logic exit_busy,
  output logic exit_done,
  output logic [63:0] ip_out,
  output logic [31:0] eax_out,
  output logic [63:0] rbx_out,
  output logic [63:0] rcx_out,
  output logic [15:0] frame_index_out,
  output logic ext_feature_write,
  output logic [63:0] ext_feature_out,
  output logic [NUM_CODE_BP-1:0] bp_reenable,
  output logic shadow_save_write,
  output logic [63:0] shadow_save_value,
  output logic tracker_save_write,
  output logic [1:0] tracker_save_value,
  output logic suppress_save_value,
  output logic host_flow_write,
  output eax_flow_t host_flow_out,
  output logic host_ssp_write,
  output logic [63:0] host_ssp_out,
  output logic protected_mode_flag,
  output logic translation_flush,
  output logic debug_restore,
  output logic trap_flag_out,
  output logic monitor_trap_pend,
  output logic fault_addr_write,
  output logic [63:0] fault_addr_out,
  output eax_exit_info_t exit_cause_record,
  output logic deliver_event
);

  // ==========================================
  // state machine
  typedef enum logic [4:0] {
    EAX_IDLE = 5'b00001,
    EAX_LOAD = 5'b00010,
    EAX_FLOW = 5'b00100,
    EAX_MODE = 5'b01000,
    EAX_DONE = 5'b10000
  } eax_state_t;

  eax_state_t state_r, state_nxt;

  // ==========================================
  // leaf decode
  eax_decode_t dec_w;
  wire logic mode64 = efer_long_active && cs_long;

  eax_leaf_decode u_dec (
    .is_supervisor(insn_is_supervisor),
    .selector(insn_eax),
    .mode64(mode64),
    .dec(dec_w)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      insn_decode <= '0;
      insn_fault <= 1'b0;
    end else begin
      insn_decode <= insn_valid ? dec_w : '0; // see RULE_01
      insn_fault <= insn_valid && dec_w.fault; // see RULE_26
    end
  end

  // ==========================================
  // event capture; events are ignored while an exit runs
  wire logic start = (state_r == EAX_IDLE) && event_valid && protected_mode_flag_set; // see RULE_23
  logic [7:0] vec_r;
  logic rep_r;
  logic flow_ss_r, flow_ibt_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EAX_IDLE: if (start) state_nxt = EAX_LOAD;
      EAX_LOAD: state_nxt = EAX_FLOW;
      EAX_FLOW: state_nxt = EAX_MODE;
      EAX_MODE: state_nxt = EAX_DONE;
      EAX_DONE: state_nxt = EAX_IDLE;
      default: state_nxt = EAX_IDLE;
    endcase
  end

  wire logic in_load = (state_r == EAX_LOAD);
  wire logic in_flow = (state_r == EAX_FLOW);
  wire logic in_mode = (state_r == EAX_MODE);
  wire logic in_done = (state_r == EAX_DONE);
  // truncation to 32 bits outside 64-bit mode
  wire logic [63:0] addr_mask = mode64 ? 64'hffffffffffffffff : 64'h00000000ffffffff; // see RULE_02

  wire logic is_bp = (vec_r == VEC_BREAKPOINT);
  wire logic is_pf = (vec_r == VEC_PAGE_FAULT);
  wire logic flow_sup = saved_host_flow.ibt_sup || saved_host_flow.ss_sup;
  wire logic host_ibt = saved_host_flow.cr4_cet && saved_host_flow.branch_tracking_enable;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= EAX_IDLE;
      vec_r <= 8'h00;
      rep_r <= 1'b0;
      flow_ss_r <= 1'b0;
      flow_ibt_r <= 1'b0;
    end else begin
      state_r <= state_nxt; // see RULE_25
      if (start) begin
        vec_r <= event_vector;
        rep_r <= event_reported;
        flow_ss_r <= flow_in.encl_cap && flow_in.cr4_cet && flow_in.shadow_stack_enable;
        flow_ibt_r <= flow_in.encl_cap && flow_in.cr4_cet && flow_in.branch_tracking_enable;
      end
    end
  end

  // ==========================================
  // register loads and exit record
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      exit_busy <= 1'b0;
      ip_out <= '0;
      eax_out <= '0;
      rbx_out <= '0;
      rcx_out <= '0;
      frame_index_out <= '0;
      ext_feature_write <= 1'b0;
      ext_feature_out <= '0;
      exit_cause_record <= '0;
    end else begin
      exit_busy <= (state_nxt != EAX_IDLE); // see RULE_25
      ext_feature_write <= in_load && os_ext_state_enable; // see RULE_13
      if (in_load) begin
        ip_out <= exit_handler_pointer & addr_mask; // see RULE_08
        eax_out <= USR_RESUME_LEAF; // see RULE_09
        rbx_out <= thread_struct_linear_addr & addr_mask; // see RULE_10
        rcx_out <= exit_handler_pointer & addr_mask; // see RULE_11
        frame_index_out <= current_save_frame_index + FRAME_INDEX_STEP; // see RULE_12
        ext_feature_out <= saved_ext_feature_ctrl; // see RULE_13
        exit_cause_record.valid <= rep_r; // see RULE_24
        exit_cause_record.vector <= rep_r ? vec_r : 8'h00;
        exit_cause_record.exit_type <= !rep_r ? 3'h0 :
                                       (is_bp ? EXIT_TYPE_BREAKPOINT : EXIT_TYPE_OTHER);
      end
    end
  end

  // ==========================================
  // per breakpoint re-enable
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CODE_BP; gi = gi + 1) begin : g_bp
      wire logic en = in_load ? bp_outside_range[gi] : // see RULE_14
                      (in_mode && !debug_opt_in_flag); // see RULE_19
      always_ff @(posedge core_clk) begin
        if (!reset_n) bp_reenable[gi] <= 1'b0;
        else bp_reenable[gi] <= en;
      end
    end
  endgenerate

  // ==========================================
  // flow-protection save and host restore
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shadow_save_write <= 1'b0;
      shadow_save_value <= '0;
      tracker_save_write <= 1'b0;
      tracker_save_value <= '0;
      suppress_save_value <= 1'b0;
      host_flow_write <= 1'b0;
      host_flow_out <= '0;
      host_ssp_write <= 1'b0;
      host_ssp_out <= '0;
    end else begin
      // enclave state is saved in the same cycle that host values are restored
      shadow_save_write <= in_flow && flow_ss_r; // see RULE_15
      tracker_save_write <= in_flow && flow_ibt_r; // see RULE_16
      host_flow_write <= in_flow && flow_sup; // see RULE_17
      host_ssp_write <= in_flow && saved_host_flow.ss_sup; // see RULE_17
      if (in_flow) begin
        shadow_save_value <= shadow_stack_pointer;
        tracker_save_value <= flow_in.tracker;
        suppress_save_value <= flow_in.suppress;
        host_ssp_out <= saved_host_shadow_pointer;
        host_flow_out <= saved_host_flow;
        if (host_ibt) begin // see RULE_17
          host_flow_out.tracker <= TRACKER_WAIT_FOR_TARGET;
          host_flow_out.suppress <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // mode exit, debug restore, fault address, hand-off
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      protected_mode_flag <= 1'b0;
      translation_flush <= 1'b0;
      debug_restore <= 1'b0;
      trap_flag_out <= 1'b0;
      monitor_trap_pend <= 1'b0;
      fault_addr_write <= 1'b0;
      fault_addr_out <= '0;
      exit_done <= 1'b0;
      deliver_event <= 1'b0;
    end else begin
      // mode flag mirrors the core's flag until this exit clears it
      // held low through delivery too, so the flag never reappears beside deliver_event
      protected_mode_flag <= (in_mode || in_done) ? 1'b0 : protected_mode_flag_set; // see RULE_18
      translation_flush <= in_done; // see RULE_18
      debug_restore <= in_mode && !debug_opt_in_flag; // see RULE_19
      if (in_mode && !debug_opt_in_flag) trap_flag_out <= saved_trap_flag; // see RULE_19
      monitor_trap_pend <= in_done && monitor_trap_ctrl; // see RULE_20
      fault_addr_write <= in_mode && is_pf; // see RULE_21
      if (in_mode && is_pf) fault_addr_out <= fault_addr_in & ~FAULT_ADDR_LOW_MASK;
      exit_done <= in_done;
      deliver_event <= in_done; // see RULE_22
    end
  end

endmodule : eax_exit_unit

//--- testbench/eax_exit_chk.sv
// checker: timing and value relations of the exit unit
`timescale 1ns/1ps
module eax_exit_chk import eax_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic event_valid,
  input wire logic protected_mode_flag_set,
  input wire logic [15:0] current_save_frame_index,
  input wire logic os_ext_state_enable,
  input wire logic [63:0] saved_ext_feature_ctrl,
  input wire logic [NUM_CODE_BP-1:0] bp_outside_range,
  input wire logic debug_opt_in_flag,
  input wire logic monitor_trap_ctrl,
  input wire logic [63:0] fault_addr_in,
  input wire logic exit_busy,
  input wire logic exit_done,
  input wire logic [63:0] ip_out,
  input wire logic [31:0] eax_out,
  input wire logic [63:0] rcx_out,
  input wire logic [15:0] frame_index_out,
  input wire logic ext_feature_write,
  input wire logic [63:0] ext_feature_out,
  input wire logic [NUM_CODE_BP-1:0] bp_reenable,
  input wire logic protected_mode_flag,
  input wire logic translation_flush,
  input wire logic debug_restore,
  input wire logic monitor_trap_pend,
  input wire logic fault_addr_write,
  input wire logic [63:0] fault_addr_out,
  input wire logic deliver_event
);
  // ==========================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_take;
    event_valid && protected_mode_flag_set && !exit_busy |=> exit_busy;
  endproperty
  a_take: assert property (p_take) else $error("event not taken");
  property p_refuse;
    event_valid && !protected_mode_flag_set && !exit_busy |=> !exit_busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("exit outside enclave");
  // fixed length keeps other events out until delivery starts
  property p_seq;
    $rose(exit_busy) |-> exit_busy[*4] ##1 (!exit_busy && exit_done && deliver_event);
  endproperty
  a_seq: assert property (p_seq) else $error("exit sequence length");
  property p_regs;
    $rose(exit_busy) |=> eax_out == 32'h3 && rcx_out == ip_out
      && frame_index_out == current_save_frame_index + FRAME_INDEX_STEP;
  endproperty
  a_regs: assert property (p_regs) else $error("resume regs");
  property p_xcr;
    $rose(exit_busy) |=> ext_feature_write == os_ext_state_enable
      && (!os_ext_state_enable || ext_feature_out == saved_ext_feature_ctrl);
  endproperty
  a_xcr: assert property (p_xcr) else $error("feature ctrl restore");
  property p_bp;
    $rose(exit_busy) |=> bp_reenable == bp_outside_range ##2 (debug_opt_in_flag || &bp_reenable);
  endproperty
  a_bp: assert property (p_bp) else $error("breakpoint reenable");
  property p_mode;
    $rose(exit_busy) |-> ##3 (!protected_mode_flag && debug_restore == !debug_opt_in_flag)
      ##1 (translation_flush && monitor_trap_pend == monitor_trap_ctrl);
  endproperty
  a_mode: assert property (p_mode) else $error("mode clear order");
  property p_pf;
    fault_addr_write |-> fault_addr_out == (fault_addr_in & ~FAULT_ADDR_LOW_MASK);
  endproperty
  a_pf: assert property (p_pf) else $error("fault address mask");
endmodule : eax_exit_chk

//--- testbench/eax_core_model.sv
// partner: pipeline side that raises events and tracks enclave residency
`timescale 1ns/1ps
module eax_core_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fire,
  input wire logic enter,
  input wire logic [7:0] vec,
  input wire logic rep,
  input wire logic exit_busy,
  input wire logic protected_mode_flag,
  input wire logic deliver_event,
  output logic event_valid,
  output logic [7:0] event_vector,
  output logic event_reported,
  output logic protected_mode_flag_set,
  output int n_deliver
);
  // ==========================================
  // event source
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      {event_valid, event_vector, event_reported, protected_mode_flag_set} <= '0;
      n_deliver <= 0;
    end else begin
      event_valid <= fire;
      // vector only meaningful beside the pulse, so it churns otherwise
      event_vector <= fire ? vec : ~event_vector;
      event_reported <= fire ? rep : ~event_reported;
      if (exit_busy && !protected_mode_flag) begin
        protected_mode_flag_set <= 1'b0;
      end else if (enter) begin
        protected_mode_flag_set <= 1'b1;
      end
      if (deliver_event) begin
        n_deliver <= n_deliver + 1;
      end
    end
  end
endmodule : eax_core_model

//--- testbench/tb.sv
// testbench: leaf decode sweep and exit sequences
`timescale 1ns/1ps
module tb import eax_pkg::*; ();
  logic core_clk, reset_n, insn_valid, insn_is_supervisor, efer_long_active, cs_long;
  logic [31:0] insn_eax, eax_out;
  eax_decode_t insn_decode;
  eax_exit_info_t exit_cause_record;
  eax_flow_t flow_in, saved_host_flow, host_flow_out;
  logic insn_fault, event_valid, event_reported, protected_mode_flag_set, os_ext_state_enable;
  logic debug_opt_in_flag, saved_trap_flag, monitor_trap_ctrl, exit_busy, exit_done;
  logic ext_feature_write, shadow_save_write, tracker_save_write, suppress_save_value;
  logic host_flow_write, host_ssp_write, protected_mode_flag, translation_flush;
  logic debug_restore, trap_flag_out, monitor_trap_pend, fault_addr_write, deliver_event;
  logic [7:0] event_vector, vec;
  logic [63:0] exit_handler_pointer, thread_struct_linear_addr, saved_ext_feature_ctrl;
  logic [63:0] fault_addr_in, shadow_stack_pointer, saved_host_shadow_pointer, ip_out;
  logic [63:0] rbx_out, rcx_out, ext_feature_out, shadow_save_value, host_ssp_out;
  logic [63:0] fault_addr_out;
  logic [15:0] current_save_frame_index, frame_index_out;
  logic [NUM_CODE_BP-1:0] bp_outside_range, bp_reenable;
  logic [1:0] tracker_save_value;
  logic fire, enter, rep;
  int n_deliver, n_mismatch, compares, k, n_flow_wr;
  logic [7:0] vt [3] = '{8'h03, 8'h0e, 8'h20};

  eax_exit_unit u_eax_exit_unit (.*);
  eax_core_model u_eax_core_model (.*);

  always #2 core_clk = ~core_clk;

  // save and restore strobes are one-cycle pulses, so count them as they stand
  always @(posedge core_clk) begin
    if (shadow_save_write && tracker_save_write && host_flow_write && host_ssp_write) begin
      n_flow_wr <= n_flow_wr + 1;
    end
  end

  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic dec(input logic s, input logic [31:0] x);
    @(posedge core_clk);
    {insn_valid, insn_is_supervisor, insn_eax} <= {1'b1, s, x};
    @(posedge core_clk);
    insn_valid <= 1'b0;
    #1;
  endtask : dec

  task automatic ex(input logic [7:0] v, input logic r);
    @(posedge core_clk);
    {fire, vec, rep} <= {1'b1, v, r};
    @(posedge core_clk);
    fire <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      #1;
      if (exit_done === 1'b1) break;
    end
  endtask : ex

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ==========================================
  // tests
  initial begin
    {core_clk, reset_n, insn_valid, insn_is_supervisor, insn_eax, fire, enter, rep, vec} = '0;
    {efer_long_active, cs_long, saved_trap_flag} = 3'b111;
    {os_ext_state_enable, debug_opt_in_flag, monitor_trap_ctrl} = 3'b000;
    exit_handler_pointer = 64'h0000_0000_0040_1000;
    thread_struct_linear_addr = 64'h0000_7f00_1234_2000;
    current_save_frame_index = 16'h00ff;
    saved_ext_feature_ctrl = 64'h0000_0000_0000_0207;
    fault_addr_in = 64'h0000_7fff_dead_beef;
    shadow_stack_pointer = 64'h0000_7fff_ffff_f000;
    saved_host_shadow_pointer = 64'h0000_7ffe_0000_0ff8;
    bp_outside_range = 4'h5;
    flow_in = eax_flow_t'(9'h1fd);
    saved_host_flow = eax_flow_t'(9'h1ff);
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    for (k = 0; k < 22; k++) begin
      dec(1'b1, 32'(k));
      chk("sup fault", 64'(k > 19), 64'(insn_fault));
    end
    for (k = 0; k < 11; k++) begin
      dec(1'b0, 32'(k));
      chk("usr fault", 64'(k == 8 || k == 10), 64'(insn_fault));
    end
    dec(1'b0, USR_ENTRY_LEAF);
    chk("entry rbx", 64'(EAX_ROLE_STRUCT_ADDR), 64'(insn_decode.rbx_role));
    chk("entry eax", 64'(EAX_ROLE_FRAME_OUT), 64'(insn_decode.eax_role));
    chk("entry rcx", 64'(EAX_ROLE_RETURN_OUT), 64'(insn_decode.rcx_role));
    chk("wide", 64'h1, 64'(insn_decode.wide));
    dec(1'b1, SUP_DEBUG_READ_LEAF);
    chk("rd rbx", 64'(EAX_ROLE_DATA_OUT), 64'(insn_decode.rbx_role));
    chk("rd rcx", 64'(EAX_ROLE_PAGE_ADDR), 64'(insn_decode.rcx_role));
    cs_long <= 1'b0;
    dec(1'b1, SUP_DEBUG_WRITE_LEAF);
    chk("wr rbx", 64'(EAX_ROLE_DATA_IN), 64'(insn_decode.rbx_role));
    chk("narrow", 64'h0, 64'(insn_decode.wide));
    $display("test decode done");
    for (k = 0; k < 3; k++) begin
      @(posedge core_clk);
      {enter, debug_opt_in_flag, os_ext_state_enable} <= {1'b1, k[0], !k[0]};
      {monitor_trap_ctrl, cs_long} <= {k == 0, k != 2};
      @(posedge core_clk);
      enter <= 1'b0;
      ex(vt[k], k != 2);
      chk("done", 64'h1, 64'(exit_done));
      chk("ip", exit_handler_pointer, ip_out);
      chk("mode flag", 64'h0, 64'(protected_mode_flag));
      chk("rbx", k == 2 ? 64'h1234_2000 : thread_struct_linear_addr, rbx_out);
      chk("record", k == 2 ? 64'h0 : 64'({1'b1, k == 0 ? 3'h6 : 3'h3, vt[k]}),
        64'(exit_cause_record));
      if (k == 1) chk("cr2", 64'h0000_7fff_dead_b000, fault_addr_out);
      if (k == 0) begin
        chk("ssp save", shadow_stack_pointer, shadow_save_value);
        chk("trap flag", 64'h1, 64'(trap_flag_out));
        chk("trk save", 64'h2, 64'(tracker_save_value));
        chk("sup save", 64'h1, 64'(suppress_save_value));
        chk("host trk", 64'(TRACKER_WAIT_FOR_TARGET), 64'(host_flow_out.tracker));
        chk("host sup", 64'h0, 64'(host_flow_out.suppress));
        chk("host ssp", saved_host_shadow_pointer, host_ssp_out);
      end
      $display("test exit %0d done", k);
    end
    ex(8'h0e, 1'b1);
    chk("refused", 64'h0, 64'(exit_busy));
    chk("deliveries", 64'h3, 64'(n_deliver));
    chk("flow writes", 64'h3, 64'(n_flow_wr));
    $display("test refusal done");
    results();
  end

  initial begin
    #20000;
    n_mismatch++;
    results();
  end
endmodule : tb

bind eax_exit_unit eax_exit_chk u_eax_exit_chk (.*);
